// >>> lcd_glass_model.sv
// Purpose: passive multiplexed glass panel watching the driver pins
// Assumes: a selected common sits on a rail, idle commons sit between rails
// Notes: a pixel is lit when its common and segment sit on opposite rails
`timescale 1ns/1ns
module lcd_glass_model (
   input wire logic quarter,
   input wire logic [43:0][2:0] pin_level,
   output logic [7:0] com_sel,
   output logic [43:0] seg_lit
);
   logic [2:0] top;
   logic [2:0] com_lvl;
   // ----------------------------------------------------------------
   // pixel decode
   // ----------------------------------------------------------------
   // the glass has no clock, so every pixel follows the pin levels at once
   always_comb begin
      top = quarter ? 3'h3 : 3'h4;
      com_sel = '0;
      com_lvl = '0;
      for (int c = 0; c < 8; c++) begin
         if (!(quarter && c > 3) && (pin_level[36+c] == 3'h0 || pin_level[36+c] == top)) begin
            com_sel[c] = 1'b1;
            com_lvl = pin_level[36+c];
         end
      end
      for (int p = 0; p < 44; p++) begin
         seg_lit[p] = (com_lvl == top && pin_level[p] == 3'h0) ||
                      (com_lvl == 3'h0 && pin_level[p] == top && com_sel != 8'h00);
      end
   end
endmodule

// >>> lcd_pkg.sv
// Purpose: constants and types for the segment display driver
// Assumes: hclk at 20 MHz, sub clock arrives as a one-cycle tick
// Notes: register offsets are word indices on the AHB-Lite slave; byte address = index * 4
package lcd_pkg;
   // ----------------------------------------------------------------
   // bus register map (word indices, byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [9:0] CTRL_W = 10'h000;
   localparam logic [9:0] CONTRAST_W = 10'h001;
   localparam logic [9:0] PSEL_W = 10'h002;
   localparam logic [9:0] STATUS_W = 10'h003;
   localparam logic [9:0] RAM_W0 = 10'h118; // byte 0460h
   localparam logic [9:0] RAM_WL = 10'h121; // byte 0484h..0487h
   localparam int RAM_WORDS = 10;
   localparam int RAM_BYTES = 40;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_FR_LO = 0; // frame_rate_field [1:0]
   localparam int CTRL_DUTY_LO = 2; // duty_select_field [3:2]
   localparam int CTRL_SUBDIS = 5; // sub_osc_disable
   localparam int CTRL_ON = 7; // display enable
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // scan timing
   // ----------------------------------------------------------------
   localparam logic [8:0] DIV_BASE = 9'h020; // sub clock / 32 at code 00
   localparam logic [2:0] LAST_COM_QTR = 3'h3;
   localparam logic [2:0] LAST_COM_OCT = 3'h7;
   localparam int SEG_PINS = 36;
   localparam int COM_PINS = 8;
   localparam int PINS = 44;
   localparam int PSEL_BITS = 24;

   // level codes on the bias ladder, index {kind, phase}
   // kind: 0 common selected, 1 common idle, 2 segment lit, 3 segment dark
   localparam logic [2:0] LVL_QTR [8] = '{3'h3, 3'h0, 3'h1, 3'h2,
                                          3'h0, 3'h3, 3'h2, 3'h1};
   localparam logic [2:0] LVL_OCT [8] = '{3'h4, 3'h0, 3'h1, 3'h3,
                                          3'h0, 3'h4, 3'h2, 3'h2};

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahb_req_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [3:0] contrast;
      logic [23:0] psel;
      logic [9:0][31:0] ram;
      logic wr_pend;
      logic [9:0] wr_addr;
      logic [31:0] rd_data;
      logic ready;
      logic resp;
      logic [7:0] div_cnt;
      logic [2:0] com_idx;
      logic phase;
      logic sub_gpio;
      logic [43:0] pin_lcd;
      logic [43:0][2:0] pin_level;
   } lcd_state_t;
endpackage

// >>> segment_lcd_driver.sv
// Purpose: segment display controller and driver behind an AHB-Lite slave
// Assumes: sub_tick pulses once per sub clock period, synchronous to hclk
// Notes: pin_level holds bias-ladder tap codes; the ladder itself is analog
//        the slave never stretches a transfer: hreadyout stays high, hresp OKAY
//        ce low freezes bus and scan together, so keep it high during traffic
//        clock source is fixed to the sub clock; bits 4 and 6 are stored only
//
// What this block does
// R1: 36 segment and 8 common pins; quarter duty turns COM4-7 into SEG39-36.
// R2: frame-rate field divides sub clock by 32, 64, 128 or 256.
// R3: frame rates 128/64/32/16 Hz quarter duty, 64/32/16/8 Hz eighth duty.
// R4: reset clears the whole control register to zero.
// R5: a shared pin drives display only while its port select bit is 0.
// R6: scanning keeps running from the sub clock in sleep and stop.
// R7: sub oscillator disable bit hands the two oscillator pins to GPIO.
// R8: software sets watch timer select 000 and keeps oscillator enabled.
// R9: software writes control bit 6 one, bit 4 zero, bit 3 one.
// R10: after reset the display clock source is the sub clock.
// R11: software waits for sub oscillator to settle before display on.
// R12: four-bit contrast field selects one of 16 contrast steps.
// R13: hardware fetches display bits from the 0460h-0487h window continually.
// R14: a display bit of 1 lights its intersection, 0 leaves it dark.
// R15: duty field bits 3:2 select the drive method, quarter or eighth duty.
// R16: drive levels come from the internal resistor bias divider.
// R17: commons are activated one at a time, segments follow that slot.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
module segment_lcd_driver (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire lcd_pkg::ahb_req_t ahb_req,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sub_tick,
   output logic [43:0][2:0] pin_level,
   output logic [43:0] pin_lcd,
   output logic [3:0] contrast_step_field,
   output logic bias_ladder_on,
   output logic sub_osc_pins_gpio
);
   import lcd_pkg::*;

   lcd_state_t st;
   lcd_state_t next_st;

   // ----------------------------------------------------------------
   // scan helpers
   // ----------------------------------------------------------------
   logic [8:0] div_lim;
   logic lcd_tick;
   logic quarter;
   logic [2:0] last_com;
   logic [39:0][7:0] ram_bytes;
   logic [43:0] pin_free;

   // divider limit from the frame-rate code, 9 bits so /256 fits
   assign div_lim = (DIV_BASE << st.ctrl[CTRL_FR_LO +: 2]) - 9'h001; // [R2]
   // >= so a smaller code written mid-count ends the slot at once
   assign lcd_tick = sub_tick && ({1'b0, st.div_cnt} >= div_lim); // [R2]
   // low duty bit set selects quarter duty
   assign quarter = st.ctrl[CTRL_DUTY_LO]; // [R15]
   assign last_com = quarter ? LAST_COM_QTR : LAST_COM_OCT; // [R15]
   assign ram_bytes = st.ram; // [R13]
   // port select only covers the first 24 pins; the rest always stay display
   assign pin_free = {20'h00000, st.psel};

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] rdv;
      logic [9:0] ri;
      logic [5:0] seg;
      logic [2:0] com;
      logic is_com;
      logic lcd;
      logic [1:0] kind;
      logic [2:0] lv;
      rdv = 32'h00000000;
      ri = 10'h000;
      seg = 6'h00;
      com = 3'h0;
      is_com = 1'b0;
      lcd = 1'b0;
      kind = 2'h0;
      lv = 3'h0;
      next_st = st;
      next_st.ready = 1'b1;
      next_st.resp = 1'b0;

      // write data phase: hwdata stands now for the captured address
      if (st.wr_pend) begin
         ri = st.wr_addr - RAM_W0;
         if (st.wr_addr == CTRL_W) begin
            next_st.ctrl = ahb_req.hwdata[7:0];
         end else if (st.wr_addr == CONTRAST_W) begin
            next_st.contrast = ahb_req.hwdata[3:0]; // [R12]
         end else if (st.wr_addr == PSEL_W) begin
            next_st.psel = ahb_req.hwdata[23:0]; // [R5]
         end else if (st.wr_addr >= RAM_W0 && st.wr_addr <= RAM_WL) begin
            next_st.ram[ri[3:0]] = ahb_req.hwdata; // [R13]
         end
      end
      next_st.wr_pend = 1'b0;

      // address phase: reads are answered from the registers right away
      if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready) begin
         next_st.wr_pend = ahb_req.hwrite;
         next_st.wr_addr = ahb_req.haddr[11:2];
         ri = ahb_req.haddr[11:2] - RAM_W0;
         if (ahb_req.haddr[11:2] == CTRL_W) begin
            rdv = {24'h000000, st.ctrl};
         end else if (ahb_req.haddr[11:2] == CONTRAST_W) begin
            rdv = {28'h0000000, st.contrast};
         end else if (ahb_req.haddr[11:2] == PSEL_W) begin
            rdv = {8'h00, st.psel};
         end else if (ahb_req.haddr[11:2] == STATUS_W) begin
            rdv = {20'h00000, st.phase, st.com_idx, st.div_cnt};
         end else if (ahb_req.haddr[11:2] >= RAM_W0 &&
                      ahb_req.haddr[11:2] <= RAM_WL) begin
            rdv = st.ram[ri[3:0]];
         end
         if (!ahb_req.hwrite) begin
            next_st.rd_data = rdv;
         end
      end

      // oscillator pins follow the disable bit
      next_st.sub_gpio = st.ctrl[CTRL_SUBDIS]; // [R7]

      // scan runs from the sub clock only, with no tie to sleep or stop,
      // so the panel stays refreshed while the core is halted [R6] [R10]
      if (sub_tick) begin
         if (lcd_tick) begin
            next_st.div_cnt = 8'h00;
            // two half slots per common keep the panel free of dc
            next_st.phase = !st.phase; // [R3]
            if (st.phase) begin
               if (st.com_idx >= last_com) begin
                  next_st.com_idx = 3'h0; // [R17]
               end else begin
                  next_st.com_idx = st.com_idx + 3'h1; // [R17]
               end
            end
         end else begin
            next_st.div_cnt = st.div_cnt + 8'h01; // [R2]
         end
      end

      // pin levels for the current common slot and half slot
      for (int p = 0; p < PINS; p++) begin
         lcd = !pin_free[p]; // [R5]
         is_com = 1'b0;
         seg = 6'h00;
         com = 3'h0;
         if (p < SEG_PINS) begin
            seg = 6'(p);
         end else if (quarter && p >= SEG_PINS + 4) begin
            seg = 6'(79 - p); // [R1]
         end else begin
            is_com = 1'b1;
            com = 3'(p - SEG_PINS); // [R1]
         end
         if (is_com) begin
            kind = (com == st.com_idx) ? 2'h0 : 2'h1; // [R17]
         end else begin
            // a stored one lights the intersection
            kind = ram_bytes[seg][st.com_idx] ? 2'h2 : 2'h3; // [R14]
         end
         // bias taps of the internal divider: 1/3 or 1/4 bias
         lv = quarter ? LVL_QTR[{kind, st.phase}] : LVL_OCT[{kind, st.phase}];
         next_st.pin_lcd[p] = lcd; // [R16]
         next_st.pin_level[p] = (st.ctrl[CTRL_ON] && lcd) ? lv : 3'h0;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // async reset clears everything, but the slave keeps reporting ready
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
         st.ctrl <= CTRL_RESET; // [R4]
         st.ready <= 1'b1;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign hrdata = st.rd_data;
   assign hreadyout = st.ready;
   assign hresp = st.resp;
   assign pin_level = st.pin_level;
   assign pin_lcd = st.pin_lcd;
   assign contrast_step_field = st.contrast; // [R12]
   assign bias_ladder_on = st.ctrl[CTRL_ON]; // [R16]
   assign sub_osc_pins_gpio = st.sub_gpio; // [R7]

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   ctrl_reset_a: assert property ($rose(hresetn) |-> st.ctrl == 8'h00) // [R4]
      else $error("control register not clear after reset");

   div_wrap_a: assert property (ce && sub_tick && lcd_tick |=> st.div_cnt == 8'h00) // [R2]
      else $error("divider did not restart at the slot end");

   com_wrap_a: assert property (ce && lcd_tick && st.phase && quarter &&
                                st.com_idx == 3'h3 |=> st.com_idx == 3'h0) // [R17]
      else $error("quarter duty scan did not wrap after common 3");

   dark_seg_a: assert property (ce && st.ctrl[CTRL_ON] && !st.psel[0] && !st.phase &&
                                !ram_bytes[0][st.com_idx] && !quarter
                                |=> st.pin_level[0] == 3'h2) // [R14]
      else $error("dark segment at wrong level");

   lit_seg_a: assert property (ce && st.ctrl[CTRL_ON] && !st.psel[1] && st.phase &&
                               ram_bytes[1][st.com_idx] && quarter
                               |=> st.pin_level[1] == 3'h3) // [R14]
      else $error("lit segment at wrong level");

   off_dark_a: assert property (ce && !st.ctrl[CTRL_ON] |=> st.pin_level[40] == 3'h0) // [R14]
      else $error("pin driven while display off");

   port_sel_a: assert property (ce && st.psel[3] |=> !st.pin_lcd[3] &&
                                st.pin_level[3] == 3'h0) // [R5]
      else $error("port pin still driven by display");

   com_reuse_a: assert property (ce && st.ctrl[CTRL_ON] && quarter && !st.phase
                                 |=> st.pin_level[43] inside {3'h0, 3'h2}) // [R1]
      else $error("common 7 not acting as a segment in quarter duty");

   osc_gpio_a: assert property (ce |=> st.sub_gpio == $past(st.ctrl[CTRL_SUBDIS])) // [R7]
      else $error("oscillator pin mode does not follow disable bit");

   // ----------------------------------------------------------------
   // bus checks
   // ----------------------------------------------------------------

   // control byte lands at the end of the write data phase
   ctrl_write_a: assert property (ce && st.wr_pend && st.wr_addr == CTRL_W // [R15]
                                  |=> st.ctrl == $past(ahb_req.hwdata[7:0]))
      else $error("control write did not land");

   // contrast nibble lands at the end of the write data phase
   contrast_write_a: assert property (ce && st.wr_pend && st.wr_addr == CONTRAST_W // [R12]
                                      |=> st.contrast == $past(ahb_req.hwdata[3:0]))
      else $error("contrast write did not land");

   // port select lands at the end of the write data phase
   psel_write_a: assert property (ce && st.wr_pend && st.wr_addr == PSEL_W // [R5]
                                  |=> st.psel == $past(ahb_req.hwdata[23:0]))
      else $error("port select write did not land");

   // last display word is reachable from the bus
   ram_write_a: assert property (ce && st.wr_pend && st.wr_addr == RAM_WL // [R13]
                                 |=> st.ram[9] == $past(ahb_req.hwdata))
      else $error("display word write did not land");

   // control reads return the stored byte with zero upper bits
   ctrl_read_a: assert property (ce && ahb_req.hsel && ahb_req.htrans[1] && // [R4]
                                 ahb_req.hready && !ahb_req.hwrite && ahb_req.haddr[11:2] == CTRL_W
                                 |=> st.rd_data == {24'h000000, $past(st.ctrl)})
      else $error("control read returned wrong data");

   // first display word reads back as stored
   ram_read_a: assert property (ce && ahb_req.hsel && ahb_req.htrans[1] && // [R13]
                                ahb_req.hready && !ahb_req.hwrite && ahb_req.haddr[11:2] == RAM_W0
                                |=> st.rd_data == $past(st.ram[0]))
      else $error("display word read returned wrong data");

   // ----------------------------------------------------------------
   // scan checks
   // ----------------------------------------------------------------

   // divider counts every sub tick inside a slot
   div_step_a: assert property (ce && sub_tick && !lcd_tick // [R2]
                                |=> st.div_cnt == $past(st.div_cnt) + 8'h01)
      else $error("divider skipped a sub tick");

   // divider only moves on a sub tick
   div_hold_a: assert property (ce && !sub_tick // [R6]
                                |=> $stable(st.div_cnt))
      else $error("divider moved without a sub tick");

   // each slot end swaps the half slot
   phase_flip_a: assert property (ce && lcd_tick // [R3]
                                  |=> st.phase != $past(st.phase))
      else $error("half slot did not swap");

   // common index holds until the second half slot ends
   com_hold_a: assert property (ce && !(lcd_tick && st.phase) // [R17]
                                |=> $stable(st.com_idx))
      else $error("common index moved mid slot");

   // common index steps by one inside the frame
   com_step_a: assert property (ce && lcd_tick && st.phase && st.com_idx < last_com // [R17]
                                |=> st.com_idx == $past(st.com_idx) + 3'h1)
      else $error("common index did not step");

   // eighth duty wraps after common 7
   com_wrap8_a: assert property (ce && lcd_tick && st.phase && !quarter && // [R15]
                                 st.com_idx == 3'h7 |=> st.com_idx == 3'h0)
      else $error("eighth duty scan did not wrap after common 7");

   // ----------------------------------------------------------------
   // pin checks
   // ----------------------------------------------------------------

   // selected common sits on the top tap in the first half slot
   com_sel_a: assert property (ce && st.ctrl[CTRL_ON] && !quarter && st.com_idx == 3'h0 && // [R17]
                               !st.phase |=> st.pin_level[36] == 3'h4)
      else $error("selected common at wrong level");

   // idle common sits on an inner tap
   com_idle_a: assert property (ce && st.ctrl[CTRL_ON] && quarter && st.com_idx != 3'h0 && // [R17]
                                st.phase |=> st.pin_level[36] == 3'h2)
      else $error("idle common at wrong level");

   // lit segment at eighth duty sits on the top tap in the second half
   lit_oct_a: assert property (ce && st.ctrl[CTRL_ON] && !st.psel[2] && !quarter && st.phase && // [R14]
                               ram_bytes[2][st.com_idx] |=> st.pin_level[2] == 3'h4)
      else $error("eighth duty lit segment at wrong level");

   // pin 40 carries segment 39 at quarter duty
   seg_reuse_a: assert property (ce && st.ctrl[CTRL_ON] && quarter && st.phase && // [R1]
                                 ram_bytes[39][st.com_idx] |=> st.pin_level[40] == 3'h3)
      else $error("segment 39 not driven on the shared pin");

   // pin 43 stays common 7 at eighth duty
   com_eight_a: assert property (ce && st.ctrl[CTRL_ON] && !quarter && st.com_idx == 3'h7 && // [R1]
                                 st.phase |=> st.pin_level[43] == 3'h0)
      else $error("common 7 not selected at eighth duty");

   // pins beyond the port select range never leave display use
   fixed_lcd_a: assert property (ce // [R5]
                                 |=> st.pin_lcd[43:24] == 20'hfffff)
      else $error("fixed display pin left display use");

   // commons rest at the bottom tap while the ladder is off
   ladder_off_a: assert property (ce && !st.ctrl[CTRL_ON] // [R16]
                                  |=> st.pin_level[36] == 3'h0)
      else $error("common driven while ladder off");
endmodule

// >>> segment_lcd_driver_test.sv
// Purpose: self-checking bench for the segment display driver
// Assumes: sub clock tick every second hclk to keep frames short
// Notes: frame lengths are counted in sub ticks, so the tick rate cancels
`timescale 1ns/1ns
module segment_lcd_driver_test;
   import lcd_pkg::*;
   logic hclk = 0;
   logic hresetn = 0;
   logic sub_tick = 0;
   logic quarter = 1;
   ahb_req_t req = '0;
   ahb_req_t bus;
   logic [31:0] hrdata, rd, first;
   logic hreadyout, hresp, bias_ladder_on, sub_osc_pins_gpio;
   logic [43:0][2:0] pin_level;
   logic [43:0] pin_lcd, seg_lit;
   logic [3:0] contrast_step_field;
   logic [7:0] com_sel;
   int fails = 0;
   int checks = 0;
   int t;
   // ----------------------------------------------------------------
   // clock, tick and instances
   // ----------------------------------------------------------------
   always #25 hclk = ~hclk;
   always @(posedge hclk) sub_tick <= ~sub_tick;
   always_comb begin
      bus = req;
      bus.hready = hreadyout;
   end
   segment_lcd_driver u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .ahb_req(bus),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sub_tick(sub_tick),
      .pin_level(pin_level), .pin_lcd(pin_lcd), .contrast_step_field(contrast_step_field),
      .bias_ladder_on(bias_ladder_on), .sub_osc_pins_gpio(sub_osc_pins_gpio));
   lcd_glass_model u_glass (.quarter(quarter), .pin_level(pin_level), .com_sel(com_sel),
      .seg_lit(seg_lit));
   task final_report;
      if (fails == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // a wait that runs out ends the run at once
   task ready_edge;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin fails++; final_report; end
   endtask
   task xfer(input logic wr, input logic [9:0] w, input logic [31:0] d);
      req.hsel <= 1'b1; req.haddr <= {20'h0, w, 2'b00}; req.htrans <= 2'b10;
      req.hwrite <= wr; req.hsize <= 3'h2;
      ready_edge;
      req.hsel <= 1'b0; req.htrans <= 2'b00; req.hwdata <= d;
      ready_edge;
      rd = hrdata;
   endtask
   function logic [7:0] pat(input int n);
      return 8'(n * 29 + 90);
   endfunction
   // counts sub ticks up to the next time common 0 becomes selected
   task rise0;
      int n;
      logic prev;
      n = 0; t = 0;
      do begin
         prev = com_sel[0];
         @(posedge hclk);
         n++;
         if (sub_tick === 1'b1) t++;
      end while (!(prev === 1'b0 && com_sel[0] === 1'b1) && n < 20000);
      if (n >= 20000) begin fails++; final_report; end
   endtask
   task scan(input int slots);
      int n, c;
      logic [7:0] prev, b;
      for (int s = 0; s < slots; s++) begin
         n = 0; prev = com_sel;
         do begin @(posedge hclk); n++; end while (com_sel === prev && n < 2000);
         if (com_sel === prev) begin fails++; final_report; end
         repeat (2) @(posedge hclk);
         c = 0;
         for (int k = 0; k < 8; k++) if (com_sel[k] === 1'b1) c = k;
         chk("one common", 32'(8'h01 << c), 32'(com_sel));
         for (int p = 0; p < 44; p++) begin
            if (p < 36 || (quarter && p > 39)) begin
               b = pat(p < 36 ? p : 79 - p);
               chk("pixel", 32'(b[c]), 32'(seg_lit[p]));
            end
         end
      end
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, CTRL_W, 32'h0); chk("ctrl reset", 32'(CTRL_RESET), rd);
      chk("levels off", 32'h0, 32'(|pin_level));
      xfer(1'b0, STATUS_W, 32'h0); first = rd;
      repeat (40) @(posedge hclk);
      xfer(1'b0, STATUS_W, 32'h0); chk("scan runs", 32'h1, 32'(rd !== first));
      xfer(1'b1, 10'h040, 32'hffffffff);
      xfer(1'b0, 10'h040, 32'h0); chk("unmapped", 32'h0, rd);
      chk("okay", 32'h0, 32'(hresp));
      for (int i = 0; i < 16; i++) begin
         xfer(1'b1, CONTRAST_W, 32'(i));
         @(posedge hclk);
         chk("contrast", 32'(i), 32'(contrast_step_field));
      end
      xfer(1'b1, CTRL_W, 32'h68);
      repeat (2) @(posedge hclk);
      chk("osc gpio", 32'h1, 32'(sub_osc_pins_gpio));
      for (int w = 0; w < RAM_WORDS; w++)
         xfer(1'b1, RAM_W0 + 10'(w), {pat(4*w+3), pat(4*w+2), pat(4*w+1), pat(4*w)});
      xfer(1'b0, RAM_W0 + 10'h1, 32'h0);
      chk("ram word", {pat(7), pat(6), pat(5), pat(4)}, rd);
      repeat (64) @(posedge hclk);
      xfer(1'b1, CTRL_W, 32'hcc);
      xfer(1'b1, PSEL_W, 32'h1);
      repeat (4) @(posedge hclk);
      chk("ladder on", 32'h1, 32'(bias_ladder_on));
      chk("port pin", 32'h4, 32'({pin_lcd[1:0], pin_level[0] != 3'h0}));
      xfer(1'b1, PSEL_W, 32'h0);
      scan(8);
      xfer(1'b1, CTRL_W, 32'hc8);
      @(posedge hclk);
      quarter <= 1'b0;
      scan(16);
      for (int d = 1; d >= 0; d--) begin
         for (int fr = 0; fr < 4; fr++) begin
            xfer(1'b1, CTRL_W, 32'hc8 | 32'(d * 4) | 32'(fr));
            @(posedge hclk);
            quarter <= d[0];
            rise0;
            rise0;
            chk("frame ticks", 32'((d ? 8 : 16) * (32 << fr)), 32'(t));
            chk("frame hz", 32'((d ? 128 : 64) >> fr), 32'(32768 / t));
         end
      end
      final_report;
   end
endmodule
